// [ufi_uart.sv]
/*
 ufi_uart: 16-byte fifo uart core with interrupt identification and infrared coding.
 assumes the cpu side strobes are single-cycle and synchronous to mclk.
*/
`timescale 1ns/1ps
module ufi_uart
    import ufi_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              resetn,
    // configuration
    input  wire ufi_cfg_t          cfg,
    input  wire logic              oscEn,
    // cpu transmit
    input  wire logic              txWrite,
    input  wire logic [7:0]        txData,
    output logic                   txReady,
    // cpu receive
    input  wire logic              rxRead,
    output logic [7:0]             rxData,
    input  wire logic              identRead,
    input  wire logic              lineRead,
    // second port pins
    input  wire logic              second_port_rx_pin,
    output logic                   second_port_tx_pin,
    output logic                   baudOut,
    // status
    output ufi_status_t            line_status_reg,
    output logic [3:0]             interrupt_ident_reg,
    output logic                   irq
);
    typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SHIFT = 3'b010, TX_STOP = 3'b100} ufi_txst_t;

    function automatic logic [3:0] nextPtr(input logic [3:0] p);
        nextPtr = p + 4'h1;
    endfunction

    logic        tick;
    logic [7:0]  rxMem [FIFO_DEPTH];
    logic [7:0]  txMem [FIFO_DEPTH];
    logic [3:0]  rxWp, rxRp, txWp, txRp;
    logic [4:0]  rxCnt, txCnt;
    logic        overrun, threPend, twoHeld, delayArm, lastFifoEn;
    logic [3:0]  rxOvs, rxBit, txOvs, txBit, delayBits, toOvs;
    logic        armEmpty;
    logic [8:0]  rxSh, txSh;
    logic        rxBusy, rxSync;
    logic [5:0]  toBits;
    logic [4:0]  askCnt;
    logic        askWave;
    ufi_txst_t   txState;

    ufi_baud_gen u_baud_gen (
        .mclk    (mclk),
        .resetn  (resetn),
        .oscEn   (oscEn),
        .divisor (cfg.divisor),
        .baudOut (baudOut),
        .tick    (tick)
    );

    // infrared receive: the pin is inverted, so a high level at the sample reads as a zero bit
    wire logic rxLine  = (cfg.irMode == IR_OFF) ? rxSync : ~rxSync;
    // done at the stop-bit sample, so a back-to-back start edge is not missed
    wire logic rxDone  = tick && rxBusy && rxOvs == OVS_LAST && rxBit == 4'h8;
    wire logic rxPush  = rxDone && rxCnt != FIFO_FULL_CNT;
    wire logic rxPop   = rxRead && rxCnt != 5'h00;
    wire logic txPush  = txWrite && txCnt != FIFO_FULL_CNT;
    wire logic txPop   = txState == TX_IDLE && txCnt != 5'h00;
    wire logic bitEnd  = tick && txOvs == OVS_LAST;
    wire logic fifoEmptyNow = txCnt == 5'h00 && txState == TX_IDLE;
    wire logic timeout = rxCnt != 5'h00 && toBits >= 6'(TIMEOUT_CHARS) * 6'(FRAME_BITS)
                         + {5'h0, cfg.twoStop};
    wire logic rxLevel = rxCnt >= cfg.rxTrigger && rxCnt != 5'h00;
    wire logic lineInt = cfg.lineIntEnable && overrun;
    wire logic rxInt   = cfg.fifoEnable && cfg.rxIntEnable && (rxLevel || timeout);
    wire logic txInt   = cfg.fifoEnable && cfg.txIntEnable && threPend;
    wire logic txBitVal = (txState == TX_SHIFT) ? txSh[0] : 1'b1;
    wire logic pulseOn = txOvs < IR_PULSE_LEN;
    wire logic next_tx = (cfg.irMode == IR_PULSE) ? (~txBitVal && pulseOn)
                       : (cfg.irMode == IR_ASK) ? (~txBitVal && askWave)
                       : txBitVal;
    wire logic [3:0] next_ident = lineInt ? ID_LINE
                                : rxInt ? (timeout && !rxLevel ? ID_TIMEOUT : ID_RXDATA)
                                : txInt ? ID_HOLDING_EMPTY_FLAG : ID_NONE;

    // receiver: 16x oversampling, character times counted on the rx clock
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            rxSync <= 1'b1;
            rxBusy <= 1'b0;
            rxOvs  <= 4'h0;
            rxBit  <= 4'h0;
            rxSh   <= 9'h000;
            toBits <= 6'h00;
            toOvs  <= 4'h0;
        end
        else
        begin
            rxSync <= second_port_rx_pin;
            // free-running bit timer; the rx sampler stops counting while idle
            if (tick)
                toOvs <= toOvs + 4'h1;
            if (rxPush || rxPop)
                toBits <= 6'h00;
            else if (tick && toOvs == OVS_LAST && toBits != 6'h3f)
                toBits <= toBits + 6'h01;
            if (tick)
            begin
                rxOvs <= rxOvs + 4'h1;
                if (!rxBusy && rxLine)
                    rxOvs <= 4'h0;
                else if (!rxBusy && rxOvs == OVS_MID)
                begin
                    rxBusy <= 1'b1;
                    rxBit  <= 4'h0;
                    rxOvs  <= 4'h0;
                end
                else if (rxBusy && rxOvs == OVS_LAST)
                begin
                    rxSh  <= {rxLine, rxSh[8:1]};
                    rxBit <= rxBit + 4'h1;
                    if (rxBit == 4'h8)
                        rxBusy <= 1'b0;
                end
            end
        end
    end

    // receive fifo and overrun
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            rxWp    <= 4'h0;
            rxRp    <= 4'h0;
            rxCnt   <= 5'h00;
            overrun <= 1'b0;
            rxData  <= 8'h00;
        end
        else
        begin
            if (rxPush)
            begin
                rxMem[rxWp] <= rxSh[8:1];
                rxWp        <= nextPtr(rxWp);
            end
            if (rxPop)
            begin
                rxData <= rxMem[rxRp];
                rxRp   <= nextPtr(rxRp);
            end
            rxCnt <= rxCnt + 5'(rxPush) - 5'(rxPop);
            if (rxDone && !rxPush)
                overrun <= 1'b1;
            else if (lineRead)
                overrun <= 1'b0;
        end
    end

    // transmitter; a load starts shifting at once
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            txWp    <= 4'h0;
            txRp    <= 4'h0;
            txCnt   <= 5'h00;
            txSh    <= 9'h1ff;
            txOvs   <= 4'h0;
            txBit   <= 4'h0;
            txState <= TX_IDLE;
        end
        else
        begin
            if (txPush)
            begin
                txMem[txWp] <= txData;
                txWp        <= nextPtr(txWp);
            end
            if (txPop)
                txRp <= nextPtr(txRp);
            txCnt <= txCnt + 5'(txPush) - 5'(txPop);
            if (tick)
                txOvs <= txOvs + 4'h1;
            case (txState)
                TX_IDLE:
                begin
                    if (txPop)
                    begin
                        txSh    <= {txMem[txRp], 1'b0};
                        txBit   <= 4'h0;
                        txOvs   <= 4'h0;
                        txState <= TX_SHIFT;
                    end
                end
                TX_SHIFT:
                begin
                    if (bitEnd)
                    begin
                        txSh  <= {1'b1, txSh[8:1]};
                        txBit <= txBit + 4'h1;
                        if (txBit == 4'h8)
                            txState <= TX_STOP;
                    end
                end
                TX_STOP:
                begin
                    if (bitEnd && (!cfg.twoStop || txBit == 4'h9))
                        txState <= TX_IDLE;
                    else if (bitEnd)
                        txBit <= txBit + 4'h1;
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end

    // holding-empty interrupt and its delay of one character less the stop bit
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            threPend   <= 1'b1;
            twoHeld    <= 1'b0;
            delayArm   <= 1'b0;
            delayBits  <= 4'h0;
            lastFifoEn <= 1'b0;
            armEmpty   <= 1'b0;
        end
        else
        begin
            lastFifoEn <= cfg.fifoEnable;
            if (txCnt >= 5'h02)
                twoHeld <= 1'b1;
            if (txPush && txCnt == 5'h00 && !twoHeld)
            begin
                delayArm  <= 1'b1;
                delayBits <= FRAME_BITS - 4'h1;
            end
            else if (delayArm && tick && txOvs == OVS_LAST && delayBits != 4'h0)
                delayBits <= delayBits - 4'h1;
            if (cfg.fifoEnable != lastFifoEn)
                threPend <= 1'b1;
            else if (armEmpty && txCnt == 5'h00 && !threPend && (!delayArm || delayBits == 4'h0 || twoHeld))
            begin
                threPend <= 1'b1;
                delayArm <= 1'b0;
                twoHeld  <= 1'b0;
                armEmpty <= 1'b0;
            end
            else if (txWrite || (identRead && interrupt_ident_reg == ID_HOLDING_EMPTY_FLAG))
                threPend <= 1'b0;
            // only an emptying after a load, or a change of fifoEnable, raises it again, not the idle level
            if (txPush)
                armEmpty <= 1'b1;
        end
    end

    // infrared carrier and registered outputs
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            askCnt              <= 5'h00;
            askWave             <= 1'b0;
            second_port_tx_pin  <= 1'b1;
            txReady             <= 1'b1;
            line_status_reg     <= '0;
            interrupt_ident_reg <= ID_NONE;
            irq                 <= 1'b0;
        end
        else
        begin
            askCnt  <= (askCnt == ASK_HALF) ? 5'h00 : askCnt + 5'h01;
            if (askCnt == ASK_HALF)
                askWave <= ~askWave;
            second_port_tx_pin <= next_tx;
            txReady <= txCnt + 5'(txPush) - 5'(txPop) != FIFO_FULL_CNT;
            line_status_reg.dataReady    <= rxCnt != 5'h00;
            line_status_reg.overrun      <= overrun;
            line_status_reg.holdingEmpty <= threPend;
            line_status_reg.txEmpty      <= fifoEmptyNow;
            line_status_reg.rxCount      <= rxCnt;
            line_status_reg.txCount      <= txCnt;
            interrupt_ident_reg <= next_ident;
            irq <= next_ident != ID_NONE;
        end
    end
endmodule

// [ufi_pkg.sv]
/*
 ufi_pkg: constants and carrier types for the fifo uart with infrared option.
 assumes a single 10 MHz system clock and a 1.8462 MHz oscillator enable input.
*/
package ufi_pkg;
    localparam int          DATA_W        = 8;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          CNT_W         = 5;
    localparam int          PTR_W         = 4;
    localparam logic [4:0]  FIFO_FULL_CNT = 5'h10;
    localparam logic [15:0] DIV_ONE       = 16'h0001;
    localparam logic [15:0] DIV_TWO       = 16'h0002;
    localparam logic [15:0] DIV_LOW_CNT   = 16'h0002;
    localparam logic [3:0]  OVS_LAST      = 4'hf;
    localparam logic [3:0]  OVS_MID       = 4'h7;
    localparam logic [3:0]  IR_PULSE_LEN  = 4'h3;
    localparam logic [3:0]  ID_NONE       = 4'h1;
    localparam logic [3:0]  ID_LINE       = 4'h6;
    localparam logic [3:0]  ID_RXDATA     = 4'h4;
    localparam logic [3:0]  ID_TIMEOUT    = 4'hc;
    localparam logic [3:0]  ID_HOLDING_EMPTY_FLAG       = 4'h2;
    localparam logic [2:0]  TIMEOUT_CHARS = 3'h4;
    localparam logic [3:0]  FRAME_BITS    = 4'ha;
    localparam int          MCLK_HZ       = 10000000;
    localparam int          ASK_HZ        = 500000;
    localparam logic [4:0]  ASK_HALF      = 5'(MCLK_HZ / ASK_HZ / 2 - 1);

    typedef enum logic [1:0] {IR_OFF = 2'h0, IR_PULSE = 2'h1, IR_ASK = 2'h2} ufi_irmode_t;

    typedef struct packed {
        logic        fifoEnable;
        logic        rxIntEnable;
        logic        txIntEnable;
        logic        lineIntEnable;
        logic [4:0]  rxTrigger;
        logic        twoStop;
        ufi_irmode_t irMode;
        logic [15:0] divisor;
    } ufi_cfg_t;

    typedef struct packed {
        logic       dataReady;
        logic       overrun;
        logic       holdingEmpty;
        logic       txEmpty;
        logic [4:0] rxCount;
        logic [4:0] txCount;
    } ufi_status_t;
endpackage

// [ufi_baud_gen.sv]
/*
 ufi_baud_gen: divider output and 16x enable derived from the oscillator enable.
 assumes oscEn pulses one mclk cycle per 1.8462 MHz oscillator edge pair.
*/
`timescale 1ns/1ps
module ufi_baud_gen
    import ufi_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // oscillator and divisor
    input  wire logic        oscEn,
    input  wire logic [15:0] divisor,
    // outputs
    output logic             baudOut,
    output logic             tick
);
    logic [15:0] count;
    logic        oscPhase;
    wire  logic  isOne  = (divisor == DIV_ONE);
    wire  logic  isTwo  = (divisor == DIV_TWO);
    wire  logic  wrap   = oscEn && (count >= divisor - DIV_ONE || divisor == 16'h0000);
    wire  logic  next_baudOut = isOne ? ~oscPhase : isTwo ? (count == 16'h0000)
                               : (count >= DIV_LOW_CNT);

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            count    <= 16'h0000;
            oscPhase <= 1'b0;
            baudOut  <= 1'b0;
            tick     <= 1'b0;
        end
        else
        begin
            if (oscEn)
                oscPhase <= ~oscPhase;
            if (oscEn)
                count <= wrap ? 16'h0000 : count + 16'h0001;
            baudOut <= next_baudOut;
            tick    <= wrap;
        end
    end
endmodule

// [ufi_uart_assertions.sv]
/*
 ufi_uart_assertions: port-level checks on the fifo uart, bound into ufi_uart.
 assumes one mclk domain with synchronous active-low resetn.
*/
`timescale 1ns/1ps
module ufi_uart_assertions
    import ufi_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // watched ports
    input  wire ufi_cfg_t    cfg,
    input  wire logic        txWrite,
    input  wire logic        txReady,
    input  wire logic        rxRead,
    input  wire logic [7:0]  rxData,
    input  wire ufi_status_t line_status_reg,
    input  wire logic [3:0]  interrupt_ident_reg,
    input  wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence rx_at_trigger;
        cfg.fifoEnable && cfg.rxIntEnable && cfg.rxTrigger != 5'h0 && line_status_reg.rxCount >= cfg.rxTrigger;
    endsequence
    sequence line_pending;
        cfg.lineIntEnable && line_status_reg.overrun;
    endsequence
    sequence tx_full;
        line_status_reg.txCount == FIFO_FULL_CNT;
    endsequence
    depth_limit_a:
        assert property (line_status_reg.rxCount <= FIFO_FULL_CNT && line_status_reg.txCount <= FIFO_FULL_CNT)
            else $error("fifo count above depth");
    full_blocks_a:
        assert property (tx_full [*2] |-> !$past(txReady)) else $error("tx ready while full");
    room_open_a:
        assert property ((line_status_reg.txCount == 5'h0) [*2] |-> txReady) else $error("tx ready low while empty");
    ready_clear_a:
        assert property ((line_status_reg.rxCount == 5'h0) [*2] |-> !line_status_reg.dataReady)
            else $error("data ready with empty fifo");
    ready_set_a:
        assert property ((line_status_reg.rxCount != 5'h0) [*2] |-> line_status_reg.dataReady)
            else $error("data ready low with data");
    trigger_ident_a:
        assert property (rx_at_trigger [*2] |-> interrupt_ident_reg inside {ID_LINE, ID_RXDATA})
            else $error("trigger level without rx ident");
    line_first_a:
        assert property (line_pending [*2] |-> interrupt_ident_reg == ID_LINE) else $error("line status outranked");
    timeout_data_a:
        assert property (interrupt_ident_reg == ID_TIMEOUT |-> line_status_reg.rxCount != 5'h0)
            else $error("timeout with empty fifo");
    timeout_clear_a:
        assert property (rxRead && interrupt_ident_reg == ID_TIMEOUT |-> ##[1:3] interrupt_ident_reg != ID_TIMEOUT)
            else $error("timeout kept after read");
    irq_follow_a:
        assert property ((interrupt_ident_reg != ID_NONE) [*2] |-> irq) else $error("irq low with ident pending");
    read_data_a:
        assert property ($changed(rxData) |-> $past(rxRead) || $past(rxRead, 2)) else $error("rx data moved unread");
endmodule
bind ufi_uart ufi_uart_assertions u_chk (.mclk(mclk), .resetn(resetn), .cfg(cfg), .txWrite(txWrite),
    .txReady(txReady), .rxRead(rxRead), .rxData(rxData), .line_status_reg(line_status_reg),
    .interrupt_ident_reg(interrupt_ident_reg), .irq(irq));

// [ufi_serial_partner.sv]
/*
 ufi_serial_partner: remote 8N1 serial device on the second port pins.
 assumes bit time of 16 x divisor oscillator enables, as the uart counts it.
*/
`timescale 1ns/1ps
module ufi_serial_partner
    import ufi_pkg::*;
(
    // clock and oscillator
    input  wire logic        mclk,
    input  wire logic        oscEn,
    input  wire logic [15:0] divisor,
    // line pins
    input  wire logic        txPin,
    output logic             rxPin
);
    logic [7:0] got[$];
    logic [7:0] b;
    // pulled-up line, idles high
    initial rxPin = 1'b1;
    task automatic osc(input int n);
        repeat (n) @(posedge mclk iff oscEn);
    endtask
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            osc(1);
            #1 rxPin = f[i];
            osc(16 * divisor - 1);
        end
    endtask
    // sample mid-bit, lsb first; a tick of phase error is tolerated
    always
    begin
        @(negedge txPin);
        osc(8 * divisor);
        repeat (8)
        begin
            osc(16 * divisor);
            b = {txPin, b[7:1]};
        end
        osc(16 * divisor);
        got.push_back(b);
    end
endmodule

// [ufi_uart_bench.sv]
/*
 ufi_uart_bench: self-checking bench, tx and rx each exercised through the serial partner.
 assumes divisor one and a 1.8462 MHz oscillator enable made from mclk.
*/
`timescale 1ns/1ps
module ufi_uart_bench
    import ufi_pkg::*;
();
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        oscEn = 1'b0;
    ufi_cfg_t    cfg;
    logic        txWrite, rxRead, identRead, lineRead, txReady, rxPin, txPin, baudOut, irq, prevTx;
    logic [7:0]  txData, rxData, b;
    ufi_status_t st;
    logic [3:0]  ident;
    int          error_cnt = 0, checks = 0, acc = 0, n;
    logic [7:0]  exp_q[$];
    ufi_uart u_dut (.mclk(mclk), .resetn(resetn), .cfg(cfg), .oscEn(oscEn), .txWrite(txWrite), .txData(txData),
        .txReady(txReady), .rxRead(rxRead), .rxData(rxData), .identRead(identRead), .lineRead(lineRead),
        .second_port_rx_pin(rxPin), .second_port_tx_pin(txPin), .baudOut(baudOut),
        .line_status_reg(st), .interrupt_ident_reg(ident), .irq(irq));
    ufi_serial_partner u_p (.mclk(mclk), .oscEn(oscEn), .divisor(cfg.divisor), .txPin(txPin), .rxPin(rxPin));
    always #50 mclk = ~mclk;
    // fractional accumulator, 1.8462 MHz from 10 MHz
    always @(posedge mclk)
    begin
        #1 acc = acc + 18462;
        oscEn = acc >= 100000;
        if (oscEn) acc = acc - 100000;
    end
    function automatic logic [3:0] rx_ident(input int cnt, input logic ovr);
        return ovr ? ID_LINE : (cnt >= int'(cfg.rxTrigger) ? ID_RXDATA : ID_NONE);
    endfunction
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_id(input logic [3:0] e, input int lim);
        repeat (lim) if (ident !== e) @(posedge mclk) #2;
        cmp("ident", {4'h0, e}, {4'h0, ident});
    endtask
    task automatic ack_holding_empty_flag(input int lim);
        wait_id(ID_HOLDING_EMPTY_FLAG, lim);
        identRead = 1'b1;
        @(posedge mclk) #1 identRead = 1'b0;
        wait_id(ID_NONE, 4);
    endtask
    task automatic wr_burst(input int cnt);
        @(posedge mclk) #1 txWrite = 1'b1;
        repeat (cnt)
        begin
            txData = 8'($urandom);
            exp_q.push_back(txData);
            @(posedge mclk) #1;
        end
        txWrite = 1'b0;
    endtask
    task automatic drain_check();
        repeat (1200) @(posedge mclk);
        cmp("txBytes", 8'(exp_q.size()), 8'(u_p.got.size()));
        while (exp_q.size() > 0 && u_p.got.size() > 0) cmp("txByte", exp_q.pop_front(), u_p.got.pop_front());
        exp_q.delete();
    endtask
    task automatic rd();
        @(posedge mclk) #1 rxRead = 1'b1;
        @(posedge mclk) #1 rxRead = 1'b0;
        @(posedge mclk) #1 cmp("rxData", exp_q.pop_front(), rxData);
    endtask
    task automatic close_out();
        if (error_cnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #8ms error_cnt++;
        close_out();
    end
    initial
    begin
        cfg = '0;
        {cfg.rxIntEnable, cfg.txIntEnable, cfg.lineIntEnable} = 3'h7;
        cfg.rxTrigger = 5'h8;
        cfg.divisor = DIV_ONE;
        {txWrite, rxRead, identRead, lineRead, txData} = '0;
        void'($urandom(82));
        repeat (12) @(posedge mclk);
        #1 resetn = 1'b1;
        @(posedge mclk) #2 cmp("resetPins", 8'h3, {6'h0, txReady, txPin});
        cmp("irq", 8'h0, {7'h0, irq});
        #1 cfg.fifoEnable = 1'b1;
        ack_holding_empty_flag(20);
        // short random burst, then a burst one past full
        wr_burst(1 + $urandom % 3);
        ack_holding_empty_flag(6000);
        drain_check();
        wr_burst(18);
        #1 cmp("txFull", 8'h10, {3'h0, st.txCount});
        void'(exp_q.pop_back());
        ack_holding_empty_flag(20000);
        drain_check();
        for (int i = 0; i < 17; i++)
        begin
            if (i == 8) wait_id(rx_ident(8, 1'b0), 20);
            b = 8'($urandom);
            if (i < 16) exp_q.push_back(b);
            u_p.send(b);
        end
        repeat (20) @(posedge mclk);
        cmp("rxFull", 8'h30, {2'h0, st.overrun, st.rxCount});
        wait_id(rx_ident(16, 1'b1), 20);
        @(posedge mclk) #1 lineRead = 1'b1;
        @(posedge mclk) #1 lineRead = 1'b0;
        wait_id(rx_ident(16, 1'b0), 10);
        repeat (9) rd();
        wait_id(rx_ident(7, 1'b0), 4);
        // 30 bit times is short of four characters
        repeat (2600) @(posedge mclk);
        cmp("early", {4'h0, ID_NONE}, {4'h0, ident});
        wait_id(ID_TIMEOUT, 2000);
        rd();
        wait_id(ID_NONE, 4);
        repeat (6) rd();
        #1 cmp("dataReady", 8'h0, {7'h0, st.dataReady});
        for (int m = 1; m < 3; m++)
        begin
            cfg.irMode = ufi_irmode_t'(m);
            @(posedge mclk) #1 {txWrite, txData} = 9'h100;
            @(posedge mclk) #1 txWrite = 1'b0;
            n = 0;
            prevTx = txPin;
            repeat (1100)
            begin
                @(posedge mclk) #2;
                n += (txPin && !prevTx) ? 1 : 0;
                prevTx = txPin;
            end
            // nine zero bits: one pulse each, or about 4.3 carrier periods each
            cmp("irEdges", 8'h1, {7'h0, m == 1 ? n == 9 : (n >= 36 && n <= 42)});
        end
        close_out();
    end
endmodule
